// ===== verilog/hpc_pkg.sv
package hpc_pkg;
    // Pin vector layout shared by the synchroniser and the core
    localparam int PIN_W = 11;
    localparam int PIN_SEL_N = 0;
    localparam int PIN_STB_A_N = 1;
    localparam int PIN_STB_B_N = 2;
    localparam int PIN_DIR = 3;
    localparam int PIN_BYTE_ID = 4;
    localparam int PIN_MOD_SEL = 5;
    localparam int PIN_WIDE = 6;
    localparam int PIN_TGT_LO = 7;
    localparam int PIN_TGT_HI = 8;
    localparam int PIN_TRST = 9;
    localparam int PIN_EMU1 = 10;
    // Select, strobes and float pin idle high, everything else low
    // Float pin must reset high or outputs float briefly after every reset
    localparam logic [PIN_W-1:0] PIN_RST = 11'h407;

    // Cycles after reset release before straps are taken (4-flop pipe filled)
    localparam logic [2:0] STRAP_DLY = 3'h4;

    // Register map, byte addresses
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_COUNT = 4'h8;

    // Control register fields
    localparam int CTRL_IRQ = 0;
    localparam int CTRL_DONE = 1;

    // Status register fields
    localparam int ST_ENABLED = 0;
    localparam int ST_WIDE = 1;
    localparam int ST_BUSY = 2;
    localparam int ST_DIR = 3;
    localparam int ST_BYTE_ID = 4;
    localparam int ST_FLOAT = 5;
    localparam int ST_TGT_LO = 8;
    localparam int ST_TGT_HI = 9;

    // Access target driven by the host
    typedef enum logic [1:0] {
        HPC_TGT_DATA = 2'b00,
        HPC_TGT_CTRL = 2'b01,
        HPC_TGT_PTR = 2'b10,
        HPC_TGT_DATA_INC = 2'b11
    } hpc_tgt_t;

    // Transfer sequencer
    typedef enum logic [1:0] {
        HPC_IDLE = 2'b00,
        HPC_ACTIVE = 2'b01,
        HPC_RELEASE = 2'b10
    } hpc_state_t;
endpackage

// ===== verilog/hpc_pins_if.sv
`timescale 1ns/1ps
interface hpc_pins_if;
    logic [hpc_pkg::PIN_W-1:0] raw;
    logic [hpc_pkg::PIN_W-1:0] stable;
    modport syncer (input raw, output stable);
    modport core (output raw, input stable);
endinterface

// ===== verilog/hpc_sync.sv
`timescale 1ns/1ps
module hpc_sync (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Pin vector
    hpc_pins_if.syncer pins
);
    logic [hpc_pkg::PIN_W-1:0] s1_r;
    logic [hpc_pkg::PIN_W-1:0] s2_r;
    logic [hpc_pkg::PIN_W-1:0] s3_r;
    logic [hpc_pkg::PIN_W-1:0] out_r;

    // Three-flop chain; s1 feeds only s2
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= hpc_pkg::PIN_RST;
            s2_r <= hpc_pkg::PIN_RST;
            s3_r <= hpc_pkg::PIN_RST;
        end else begin
            s1_r <= pins.raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A bit changes only once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < hpc_pkg::PIN_W; i++) begin : g_bit
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    out_r[i] <= hpc_pkg::PIN_RST[i];
                end else if (s2_r[i] == s3_r[i]) begin
                    out_r[i] <= s3_r[i];
                end
            end
        end
    endgenerate

    assign pins.stable = out_r;
endmodule

// ===== verilog/hpc_core.sv
`timescale 1ns/1ps
// Summary of operation
// - Host direction level sets read or write for the transfer in progress.
// - Ready output shows when the port can take the next transfer.
// - Ready output floats while the global output-disable is active.
// - Host interrupt output is driven high while the device is in reset.
// - Host interrupt output floats while the global output-disable is active.
// - Module select is sampled as reset releases; high enables the port.
// - Low module select at reset disables the port until next reset.
// - Wide select low gives byte-multiplexed mode, high gives non-multiplexed.
// - Non-multiplexed mode moves whole 16-bit words on separate buses.
// - Non-multiplexed mode has no interrupts through the host port.
// - Non-multiplexed mode gives no host access to control or pointer.
// - Wide select taken at reset holds for the whole operating period.
// - Output-disable is test reset low with emulation float pin low.
module hpc_core (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [hpc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Host-side control pins
    input wire logic host_port_select_n,
    input wire logic host_strobe_a_n,
    input wire logic host_strobe_b_n,
    input wire logic host_dir_select,
    input wire logic host_byte_identify,
    input wire logic [1:0] host_access_target,
    // Reset straps
    input wire logic host_port_module_select,
    input wire logic host_port_wide_select,
    // Test and emulation pins
    input wire logic test_reset,
    input wire logic emulation_pin1_float_n,
    // Host outputs, two-signal form (value and enable)
    output logic host_port_ready_out,
    output logic host_port_ready_oe,
    output logic host_irq_out,
    output logic host_irq_oe,
    // Transfer to core side
    output logic xfer_busy,
    output logic xfer_dir_read,
    output logic xfer_second_byte,
    output logic [1:0] xfer_target
);
    hpc_pins_if pins ();

    // Pack raw pins for the synchroniser
    assign pins.raw = {emulation_pin1_float_n, test_reset, host_access_target,
                       host_port_wide_select, host_port_module_select,
                       host_byte_identify, host_dir_select,
                       host_strobe_b_n, host_strobe_a_n, host_port_select_n};

    hpc_sync u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pins(pins.syncer)
    );

    logic [hpc_pkg::PIN_W-1:0] pin_s;
    assign pin_s = pins.stable;

    hpc_pkg::hpc_state_t state_r;
    hpc_pkg::hpc_state_t state_nxt;
    logic [2:0] strap_cnt_r;
    logic strap_done_r;
    logic enabled_r;
    logic wide_r;
    logic irq_req_r;
    logic done_req_r;
    logic dir_r;
    logic byte_id_r;
    logic [1:0] target_r;
    logic [15:0] count_r;
    logic float_r;
    logic ready_r;
    logic ready_oe_r;
    logic irq_r;
    logic irq_oe_r;
    logic busy_r;
    logic wait_r;
    logic [31:0] rdata_r;

    // Pin decode
    wire strobe_on = !(pin_s[hpc_pkg::PIN_STB_A_N] && pin_s[hpc_pkg::PIN_STB_B_N]);
    wire selected = !pin_s[hpc_pkg::PIN_SEL_N];
    wire port_live = strap_done_r && enabled_r;
    wire start = port_live && selected && strobe_on;
    wire strobe_off = !strobe_on || !selected;
    wire float_now = !pin_s[hpc_pkg::PIN_TRST] && !pin_s[hpc_pkg::PIN_EMU1];
    wire [1:0] tgt_pin = pin_s[hpc_pkg::PIN_TGT_HI:hpc_pkg::PIN_TGT_LO];
    // Wide mode maps every access to data; control and pointer unreachable
    wire [1:0] tgt_eff = wide_r ? hpc_pkg::HPC_TGT_DATA : tgt_pin;

    // Bus decode
    wire bus_req = avs_read || avs_write;
    wire bus_take = bus_req && !wait_r;
    wire hit_ctrl = avs_address == hpc_pkg::ADDR_CTRL;
    wire hit_status = avs_address == hpc_pkg::ADDR_STATUS;
    wire hit_count = avs_address == hpc_pkg::ADDR_COUNT;
    wire wr_ctrl = avs_write && bus_take && hit_ctrl;
    wire done_wr = wr_ctrl && avs_writedata[hpc_pkg::CTRL_DONE];

    wire [31:0] ctrl_word = {30'h0, done_req_r, irq_req_r};
    wire [31:0] status_word = {22'h0, target_r, 2'h0, float_r, byte_id_r, dir_r,
                               (state_r != hpc_pkg::HPC_IDLE), wide_r, enabled_r};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_word :
                         hit_status ? status_word :
                         hit_count ? {16'h0, count_r} : 32'h0;

    // Straps are taken once the pin pipe is full after reset release
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt_r <= 3'h0;
            strap_done_r <= 1'b0;
            enabled_r <= 1'b0;
            wide_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_cnt_r <= strap_cnt_r + 3'h1;
            if (strap_cnt_r == hpc_pkg::STRAP_DLY) begin
                strap_done_r <= 1'b1;
                enabled_r <= pin_s[hpc_pkg::PIN_MOD_SEL];
                wide_r <= pin_s[hpc_pkg::PIN_WIDE];
            end
        end
    end

    // Transfer sequencer: busy from strobe until software completes it and the host drops strobe or select
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            hpc_pkg::HPC_IDLE: begin
                if (start) begin
                    state_nxt = hpc_pkg::HPC_ACTIVE;
                end
            end
            hpc_pkg::HPC_ACTIVE: begin
                if (done_req_r || done_wr) begin
                    state_nxt = hpc_pkg::HPC_RELEASE;
                end
            end
            hpc_pkg::HPC_RELEASE: begin
                if (strobe_off) begin
                    state_nxt = hpc_pkg::HPC_IDLE;
                end
            end
            default: begin
                state_nxt = hpc_pkg::HPC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= hpc_pkg::HPC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Capture direction, byte order and target at transfer start
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dir_r <= 1'b0;
            byte_id_r <= 1'b0;
            target_r <= hpc_pkg::HPC_TGT_DATA;
            count_r <= 16'h0;
        end else if (state_r == hpc_pkg::HPC_IDLE && start) begin
            dir_r <= pin_s[hpc_pkg::PIN_DIR];
            byte_id_r <= !wide_r && pin_s[hpc_pkg::PIN_BYTE_ID];
            target_r <= tgt_eff;
            count_r <= count_r + 16'h1;
        end
    end

    // Control bits; a done arriving while idle is dropped, not held
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_req_r <= 1'b0;
            done_req_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                irq_req_r <= avs_writedata[hpc_pkg::CTRL_IRQ];
            end
            done_req_r <= 1'b0;
        end
    end

    // Pin drivers; interrupt is active low so reset leaves it high
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            float_r <= 1'b0;
            ready_r <= 1'b0;
            ready_oe_r <= 1'b1;
            irq_r <= 1'b1;
            irq_oe_r <= 1'b1;
            busy_r <= 1'b0;
        end else begin
            float_r <= float_now;
            ready_r <= port_live && state_nxt == hpc_pkg::HPC_IDLE;
            ready_oe_r <= !float_now;
            irq_r <= !(irq_req_r && port_live && !wide_r);
            irq_oe_r <= !float_now;
            busy_r <= state_nxt != hpc_pkg::HPC_IDLE; // Tracks state_r, but from a flop
        end
    end

    // Avalon: one wait cycle, then the answer edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0;
        end else begin
            wait_r <= !(bus_req && wait_r);
            if (bus_req && wait_r) begin
                rdata_r <= rd_mux;
            end
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;
    assign host_port_ready_out = ready_r;
    assign host_port_ready_oe = ready_oe_r;
    assign host_irq_out = irq_r;
    assign host_irq_oe = irq_oe_r;
    assign xfer_busy = busy_r;
    assign xfer_dir_read = dir_r;
    assign xfer_second_byte = byte_id_r;
    assign xfer_target = target_r;

    // Checks
    property p_ready_float;
        @(posedge clk_sys) disable iff (!rst_n)
        float_now |=> !host_port_ready_oe;
    endproperty
    a_ready_float: assert property (p_ready_float) else $error("ready driven while float");

    property p_irq_float;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(float_now) |=> !host_irq_oe && float_r;
    endproperty
    a_irq_float: assert property (p_irq_float) else $error("irq driven while float");

    property p_busy_not_ready;
        @(posedge clk_sys) disable iff (!rst_n)
        state_r == hpc_pkg::HPC_ACTIVE |-> !host_port_ready_out;
    endproperty
    a_busy_not_ready: assert property (p_busy_not_ready) else $error("ready while busy");

    sequence s_start;
        state_r == hpc_pkg::HPC_IDLE && start;
    endsequence
    sequence s_captured;
        state_r == hpc_pkg::HPC_ACTIVE && dir_r == $past(pin_s[hpc_pkg::PIN_DIR]);
    endsequence
    property p_dir_capture;
        @(posedge clk_sys) disable iff (!rst_n)
        s_start |=> s_captured;
    endproperty
    a_dir_capture: assert property (p_dir_capture) else $error("direction not captured");

    property p_disabled_idle;
        @(posedge clk_sys) disable iff (!rst_n)
        strap_done_r && !enabled_r |-> state_r == hpc_pkg::HPC_IDLE && !host_port_ready_out;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) else $error("disabled port active");

    property p_strap_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        strap_done_r |=> $stable(enabled_r) && $stable(wide_r);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed after capture");

    property p_wide_no_irq;
        @(posedge clk_sys) disable iff (!rst_n)
        strap_done_r && wide_r |=> host_irq_out;
    endproperty
    a_wide_no_irq: assert property (p_wide_no_irq) else $error("irq in wide mode");

    property p_wide_data_only;
        @(posedge clk_sys) disable iff (!rst_n)
        wide_r && xfer_busy |-> xfer_target == hpc_pkg::HPC_TGT_DATA && !xfer_second_byte;
    endproperty
    a_wide_data_only: assert property (p_wide_data_only) else $error("ctrl access in wide");

    property p_bus_answer;
        @(posedge clk_sys) disable iff (!rst_n)
        bus_req && wait_r |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing");

    property p_strap_time;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(strap_done_r) |-> $past(strap_cnt_r) == hpc_pkg::STRAP_DLY;
    endproperty
    a_strap_time: assert property (p_strap_time) else $error("strap taken early");
endmodule

// ===== verif/hpc_host_bfm.sv
`timescale 1ns/1ps
module hpc_host_bfm (
    // Clock
    input wire logic clk_sys,
    // Host control lines
    output logic host_port_select_n,
    output logic host_strobe_a_n,
    output logic host_strobe_b_n,
    output logic host_dir_select,
    output logic host_byte_identify,
    output logic [1:0] host_access_target
);
    // Parked host: select and strobes high
    initial begin
        host_port_select_n = 1'b1;
        host_strobe_a_n = 1'b1;
        host_strobe_b_n = 1'b1;
        host_dir_select = 1'b0;
        host_byte_identify = 1'b0;
        host_access_target = 2'h0;
    end

    // Select, qualifiers and one strobe together, held until release
    task automatic start(input logic rd, input logic sec, input logic [1:0] tg,
            input logic use_b);
        @(posedge clk_sys);
        host_port_select_n <= 1'b0;
        host_dir_select <= rd;
        host_byte_identify <= sec;
        host_access_target <= tg;
        host_strobe_a_n <= use_b;
        host_strobe_b_n <= ~use_b;
    endtask

    // Released qualifiers flip so a stale level is never trusted
    task automatic let_go();
        @(posedge clk_sys);
        host_port_select_n <= 1'b1;
        host_strobe_a_n <= 1'b1;
        host_strobe_b_n <= 1'b1;
        host_dir_select <= ~host_dir_select;
        host_byte_identify <= ~host_byte_identify;
        host_access_target <= ~host_access_target;
    endtask
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    // Clock, reset, straps and test pins
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic mod_sel = 1'b1;
    logic wide = 1'b0;
    logic test_reset = 1'b0;
    logic float_n = 1'b1;
    // Avalon master side
    logic [hpc_pkg::ADDR_W-1:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [31:0] rd;
    // Host lines and outputs
    logic sel_n, stb_a_n, stb_b_n, dir, byte_id;
    logic [1:0] tgt;
    logic ready, ready_oe, irq, irq_oe, busy, dir_rd, sec;
    logic [1:0] xtgt;
    int n_errors = 0;
    int checked = 0;

    always #2.5 clk_sys = ~clk_sys;

    hpc_host_bfm host_u (.clk_sys(clk_sys), .host_port_select_n(sel_n),
        .host_strobe_a_n(stb_a_n), .host_strobe_b_n(stb_b_n), .host_dir_select(dir),
        .host_byte_identify(byte_id), .host_access_target(tgt));

    hpc_core dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(address),
        .avs_read(read), .avs_write(write), .avs_writedata(writedata),
        .avs_readdata(readdata), .avs_waitrequest(waitrequest),
        .host_port_select_n(sel_n), .host_strobe_a_n(stb_a_n),
        .host_strobe_b_n(stb_b_n), .host_dir_select(dir), .host_byte_identify(byte_id),
        .host_access_target(tgt), .host_port_module_select(mod_sel),
        .host_port_wide_select(wide), .test_reset(test_reset),
        .emulation_pin1_float_n(float_n), .host_port_ready_out(ready),
        .host_port_ready_oe(ready_oe), .host_irq_out(irq), .host_irq_oe(irq_oe),
        .xfer_busy(busy), .xfer_dir_read(dir_rd), .xfer_second_byte(sec),
        .xfer_target(xtgt));

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One access; a gap edge first so two requests never share a step
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        address <= a;
        read <= ~wr;
        write <= wr;
        writedata <= d;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (waitrequest !== 1'b0) begin
            n_errors++;
            stop_test();
        end
    endtask

    // Bounded wait on busy (0) or ready (1)
    task automatic wait_for(input int which, input logic want);
        int n;
        n = 0;
        while ((which == 0 ? busy : ready) !== want && n < 40) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 40) begin
            n_errors++;
            stop_test();
        end
    endtask

    // Straps kept steady through and after release
    task automatic do_reset(input logic ms, input logic wd);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        mod_sel <= ms;
        wide <= wd;
        repeat (3) @(posedge clk_sys);
        chk(irq, 1'b1, "irq in reset");
        rst_n <= 1'b1;
        repeat (12) @(posedge clk_sys);
    endtask

    // Full host transfer closed by a done write; exp is {dir, second, target}
    task automatic xfer(input logic rdir, input logic s, input logic [1:0] t,
            input logic use_b, input logic [3:0] exp);
        wait_for(1, 1'b1);
        host_u.start(rdir, s, t, use_b);
        wait_for(0, 1'b1);
        repeat (2) @(posedge clk_sys);
        chk(ready, 1'b0, "ready while busy");
        chk({dir_rd, sec, xtgt}, exp, "captured qualifiers");
        av(1'b1, hpc_pkg::ADDR_CTRL, 32'h2);
        host_u.let_go();
        wait_for(1, 1'b1);
        chk(busy, 1'b0, "idle after release");
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        chk(irq, 1'b1, "irq in reset");
        rst_n <= 1'b1;
        repeat (12) @(posedge clk_sys);
        chk({ready_oe, irq_oe}, 2'b11, "outputs driven");
        av(1'b0, hpc_pkg::ADDR_STATUS, 32'h0);
        chk(rd[1:0], 2'b01, "enabled byte mode");
        av(1'b1, 4'hc, 32'hffffffff);
        av(1'b0, 4'hc, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        // Every target, both directions, both strobes, both bytes
        for (int i = 0; i < 4; i++) begin
            xfer(i[0], i[1], i[1:0], i[0], {i[0], i[1], i[1:0]});
        end
        av(1'b0, hpc_pkg::ADDR_COUNT, 32'h0);
        chk(rd[15:0], 16'h4, "strobe count");
        // Host interrupt raised and withdrawn in byte mode
        av(1'b1, hpc_pkg::ADDR_CTRL, 32'h1);
        repeat (3) @(posedge clk_sys);
        chk(irq, 1'b0, "irq raised");
        av(1'b0, hpc_pkg::ADDR_CTRL, 32'h0);
        chk(rd[1:0], 2'b01, "ctrl readback");
        av(1'b1, hpc_pkg::ADDR_CTRL, 32'h0);
        repeat (3) @(posedge clk_sys);
        chk(irq, 1'b1, "irq withdrawn");
        // Float only with both test pins low
        float_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk({ready_oe, irq_oe}, 2'b00, "outputs float");
        av(1'b0, hpc_pkg::ADDR_STATUS, 32'h0);
        chk(rd[5], 1'b1, "float status");
        test_reset <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk({ready_oe, irq_oe}, 2'b11, "no float in test");
        test_reset <= 1'b0;
        float_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk({ready_oe, irq_oe}, 2'b11, "driven again");
        // Wide mode: no control access, no interrupt
        do_reset(1'b1, 1'b1);
        av(1'b0, hpc_pkg::ADDR_STATUS, 32'h0);
        chk(rd[1:0], 2'b11, "wide mode");
        xfer(1'b1, 1'b1, 2'h1, 1'b0, 4'h8);
        av(1'b1, hpc_pkg::ADDR_CTRL, 32'h1);
        repeat (3) @(posedge clk_sys);
        chk(irq, 1'b1, "no irq in wide");
        av(1'b1, hpc_pkg::ADDR_CTRL, 32'h0);
        av(1'b0, hpc_pkg::ADDR_STATUS, 32'h0);
        chk(rd[1], 1'b1, "wide kept");
        // Disabled port ignores later select and strobes
        do_reset(1'b0, 1'b0);
        mod_sel <= 1'b1;
        host_u.start(1'b1, 1'b0, 2'h0, 1'b0);
        repeat (10) @(posedge clk_sys);
        chk({busy, ready}, 2'b00, "disabled ignores host");
        av(1'b0, hpc_pkg::ADDR_STATUS, 32'h0);
        chk(rd[0], 1'b0, "port disabled");
        av(1'b0, hpc_pkg::ADDR_COUNT, 32'h0);
        chk(rd[15:0], 16'h0, "no access");
        host_u.let_go();
        stop_test();
    end
endmodule
